// ===== hdl/fpcc_pkg.sv
package fpcc_pkg;

   // operations accepted at issue
   typedef enum logic [2:0] {
      OP_NONE,
      OP_CMP_DOUBLE,
      OP_CMP_SINGLE,
      OP_CMP_UNSIGNED,
      OP_DOUBLE_TO_INT,
      OP_DOUBLE_TO_SINGLE
   } fpcc_op_t;

   // status flags reported with each written result
   typedef struct packed {
      logic       unordered;
      logic       invalid_op;
      logic       inexact;
      logic       overflow;
      logic       underflow;
      logic       src2_denormal;
      logic       src2_nan;
      logic       infinity_out;
      logic [1:0] operand_nan;
      logic [1:0] operand_denormal;
   } fpcc_flags_t;

   typedef struct packed {
      logic        we;
      logic [31:0] dst;
      fpcc_flags_t flags;
   } fpcc_result_t;

   localparam int CNV_DELAY_SLOTS = 3;

   // whole state of the unit
   typedef struct packed {
      logic                               dp_pend;
      logic                               dp_cond;
      logic [31:0]                        lo1;
      logic [31:0]                        lo2;
      fpcc_result_t                       cmp;
      fpcc_result_t [CNV_DELAY_SLOTS-1:0] pipe;
      fpcc_result_t                       cnv;
   } fpcc_state_t;

   // rounding mode field of the adder configuration register
   localparam logic [1:0] RM_NEAREST = 2'h0;
   localparam logic [1:0] RM_ZERO    = 2'h1;
   localparam logic [1:0] RM_PINF    = 2'h2;
   localparam logic [1:0] RM_NINF    = 2'h3;

   // opfields of the unsigned compare
   localparam logic [6:0] OPF_REG_REG   = 7'h5F;
   localparam logic [6:0] OPF_CST_REG   = 7'h5E;
   localparam logic [6:0] OPF_REG_LONG  = 7'h5D;
   localparam logic [6:0] OPF_CST_LONG  = 7'h5C;

   localparam logic [31:0] SAT_POS          = 32'h7FFF_FFFF;
   localparam logic [31:0] SAT_NEG          = 32'h8000_0000;
   localparam logic [31:0] QUIET_NAN_RESULT = 32'h7FFF_FFFF;
   localparam logic [30:0] SP_INF_MAG       = 31'h7F80_0000;
   localparam logic [30:0] LARGEST_SINGLE_MAGNITUDE  = 31'h7F7F_FFFF;
   localparam logic [30:0] SMALLEST_SINGLE_MAGNITUDE = 31'h0080_0000;

   localparam logic signed [12:0] DP_BIAS    = 13'sh03FF;
   localparam logic signed [12:0] SP_BIAS    = 13'sh007F;
   localparam logic signed [12:0] INT_MAX_UE = 13'sh001F;
   localparam logic signed [12:0] SP_MAX_UE  = 13'sh007F;
   localparam logic signed [12:0] SP_MIN_UE  = -13'sh007E;
   localparam logic [8:0]         SP_MAX_EXP = 9'h0FE;

endpackage

// ===== hdl/fpcc_unit.sv
`timescale 1ns/1ps
// Function
// - float compares set only unordered, invalid, operand NaN and denormal flags
// - double compare reads low halves E1, high halves E2, writes in E2
// - single compare reads and writes in one stage, no delay slots
// - unsigned compare writes 1 when src1 below src2, else 0
// - unsigned compare operand forms chosen by opfield 5F down to 5C
// - double to int takes high word on src2, low word on src1, one cycle
// - double to int NaN gives saturated integer and invalid flag
// - double to int infinity or out of range gives signed saturation, inexact, overflow
// - double to int denormal gives zero, inexact, src2 denormal
// - both conversions flag inexact whenever rounding happened
// - double to int reads in E1, writes in E4, three delay slots
// - double to single overflow result chosen by rounding mode and sign
// - underflow sets inexact, underflow; signed zero or smallest by mode
// - double to int rounds by adder configuration rounding mode
module fpcc_unit (
   // clock, reset, enable
   input  wire logic                   I_REF_CLK,
   input  wire logic                   I_NRST,
   input  wire logic                   I_CE,
   // issue
   input  wire logic                   I_ISSUE,
   input  wire fpcc_pkg::fpcc_op_t     I_OP,
   input  wire logic                   I_COND,
   input  wire logic [6:0]             I_OPFIELD,
   // operands and configuration
   input  wire logic [31:0]            I_SRC1,
   input  wire logic [31:0]            I_SRC2,
   input  wire logic [7:0]             I_SRC2_HI,
   input  wire logic [1:0]             I_RMODE,
   // results
   output fpcc_pkg::fpcc_result_t      O_CMP_RES,
   output fpcc_pkg::fpcc_result_t      O_CNV_RES,
   output logic                        O_BUSY
);

   fpcc_pkg::fpcc_state_t st;
   fpcc_pkg::fpcc_state_t next_st;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic is_nan(input logic [63:0] x, input logic dbl);
      return dbl ? (&x[62:52] && |x[51:0]) : (&x[30:23] && |x[22:0]);
   endfunction

   function automatic logic is_den(input logic [63:0] x, input logic dbl);
      return dbl ? (~|x[62:52] && |x[51:0]) : (~|x[30:23] && |x[22:0]);
   endfunction

   // magnitude with denormals flushed to zero
   function automatic logic [62:0] mag(input logic [63:0] x,
                                       input logic dbl);
      if (is_den(x, dbl))
         return 63'h0;
      return dbl ? x[62:0] : {32'h0, x[30:0]};
   endfunction

   function automatic logic rnd_inc(input logic [1:0] rm, input logic s,
                                    input logic lsb, input logic g,
                                    input logic sticky);
      case (rm)
         fpcc_pkg::RM_NEAREST: return g & (sticky | lsb);
         fpcc_pkg::RM_PINF:    return ~s & (g | sticky);
         fpcc_pkg::RM_NINF:    return s & (g | sticky);
         default:              return 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   function automatic fpcc_pkg::fpcc_result_t cmp_fp(input logic [63:0] a,
                                                     input logic [63:0] b,
                                                     input logic dbl);
      fpcc_pkg::fpcc_result_t r;
      logic [1:0]  nan;
      logic        sa;
      logic        sb;
      logic [62:0] ma;
      logic [62:0] mb;
      logic        lt;
      r   = '0;
      nan = {is_nan(b, dbl), is_nan(a, dbl)};
      sa  = dbl ? a[63] : a[31];
      sb  = dbl ? b[63] : b[31];
      ma  = mag(a, dbl);
      mb  = mag(b, dbl);
      if (~|ma && ~|mb)
         lt = 1'b0;
      else if (sa != sb)
         lt = sa;
      else
         lt = sa ? (ma > mb) : (ma < mb);
      r.dst                    = {31'h0, lt & ~|nan};
      r.flags.unordered        = |nan;
      r.flags.invalid_op       = |nan;
      r.flags.operand_nan      = nan;
      r.flags.operand_denormal = {is_den(b, dbl), is_den(a, dbl)};
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   function automatic fpcc_pkg::fpcc_result_t cvt_int(input logic [63:0] x,
                                                      input logic [1:0] rm);
      fpcc_pkg::fpcc_result_t r;
      logic               s;
      logic signed [12:0] ue;
      logic [127:0]       w;
      logic [32:0]        q;
      logic [32:0]        m;
      logic               g;
      logic               sticky;
      r  = '0;
      s  = x[63];
      ue = $signed({2'h0, x[62:52]}) - fpcc_pkg::DP_BIAS;
      w  = '0;
      if (is_nan(x, 1'b1)) begin
         r.dst              = s ? fpcc_pkg::SAT_NEG : fpcc_pkg::SAT_POS;
         r.flags.invalid_op = 1'b1;
      end else if (&x[62:52] || ue > fpcc_pkg::INT_MAX_UE) begin
         r.dst              = s ? fpcc_pkg::SAT_NEG : fpcc_pkg::SAT_POS;
         r.flags.inexact    = 1'b1;
         r.flags.overflow   = 1'b1;
      end else if (~|x[62:52]) begin
         r.flags.inexact       = |x[51:0];
         r.flags.src2_denormal = |x[51:0];
      end else begin
         if (ue >= -13'sh0001) begin
            w = {64'h0, 1'b1, x[51:0], 11'h0} << 7'(ue + 13'sh0001);
            q = w[96:64];
            g = w[63];
            sticky = |w[62:0];
         end else begin
            q = 33'h0;
            g = 1'b0;
            sticky = 1'b1;
         end
         m = q + {32'h0, rnd_inc(rm, s, q[0], g, sticky)};
         if (s ? (m > 33'h0_8000_0000) : (m > 33'h0_7FFF_FFFF)) begin
            r.dst            = s ? fpcc_pkg::SAT_NEG : fpcc_pkg::SAT_POS;
            r.flags.inexact  = 1'b1;
            r.flags.overflow = 1'b1;
         end else begin
            r.dst           = s ? (32'h0 - m[31:0]) : m[31:0];
            r.flags.inexact = g | sticky;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   function automatic fpcc_pkg::fpcc_result_t cvt_sp(input logic [63:0] x,
                                                     input logic [1:0] rm);
      fpcc_pkg::fpcc_result_t r;
      logic               s;
      logic signed [12:0] ue;
      logic [24:0]        m;
      logic [8:0]         se;
      logic [22:0]        fr;
      logic               g;
      logic               sticky;
      logic               ovf;
      r   = '0;
      s   = x[63];
      ue  = $signed({2'h0, x[62:52]}) - fpcc_pkg::DP_BIAS;
      ovf = 1'b0;
      g   = x[28];
      sticky = |x[27:0];
      m   = {1'b0, 1'b1, x[51:29]} + {24'h0, rnd_inc(rm, s, x[29], g, sticky)};
      se  = 9'(ue + fpcc_pkg::SP_BIAS) + {8'h0, m[24]};
      fr  = m[24] ? m[23:1] : m[22:0];
      if (is_nan(x, 1'b1)) begin
         r.dst              = fpcc_pkg::QUIET_NAN_RESULT;
         r.flags.src2_nan   = 1'b1;
         r.flags.invalid_op = ~x[51];
      end else if (&x[62:52]) begin
         r.dst                = {s, fpcc_pkg::SP_INF_MAG};
         r.flags.infinity_out = 1'b1;
      end else if (~|x[62:52]) begin
         r.dst                 = {s, 31'h0};
         r.flags.inexact       = |x[51:0];
         r.flags.src2_denormal = |x[51:0];
      end else if (ue > fpcc_pkg::SP_MAX_UE) begin
         ovf = 1'b1;
      end else if (ue < fpcc_pkg::SP_MIN_UE) begin
         r.flags.inexact   = 1'b1;
         r.flags.underflow = 1'b1;
         r.dst = {s, 31'h0};
         if ((rm == fpcc_pkg::RM_PINF && !s) || (rm == fpcc_pkg::RM_NINF && s))
            r.dst = {s, fpcc_pkg::SMALLEST_SINGLE_MAGNITUDE};
      end else if (se > fpcc_pkg::SP_MAX_EXP) begin
         ovf = 1'b1;
      end else begin
         r.dst           = {s, se[7:0], fr};
         r.flags.inexact = g | sticky;
      end
      if (ovf) begin
         r.flags.inexact  = 1'b1;
         r.flags.overflow = 1'b1;
         case (rm)
            fpcc_pkg::RM_ZERO:
               r.dst = {s, fpcc_pkg::LARGEST_SINGLE_MAGNITUDE};
            fpcc_pkg::RM_PINF:
               r.dst = {s, s ? fpcc_pkg::LARGEST_SINGLE_MAGNITUDE
                             : fpcc_pkg::SP_INF_MAG};
            fpcc_pkg::RM_NINF:
               r.dst = {s, s ? fpcc_pkg::SP_INF_MAG
                             : fpcc_pkg::LARGEST_SINGLE_MAGNITUDE};
            default:
               r.dst = {s, fpcc_pkg::SP_INF_MAG};
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      fpcc_pkg::fpcc_result_t r;
      logic [39:0]            ua;
      logic [39:0]            ub;
      logic                   uok;
      r  = '0;
      ua = {8'h0, I_SRC1};
      ub = {8'h0, I_SRC2};
      uok = 1'b1;
      next_st        = st;
      next_st.cmp.we = 1'b0;
      next_st.pipe   = {st.pipe[fpcc_pkg::CNV_DELAY_SLOTS-2:0], r};
      next_st.cnv    = st.pipe[fpcc_pkg::CNV_DELAY_SLOTS-1];
      if (st.dp_pend) begin
         // second stage: high halves on the source ports
         next_st.dp_pend = 1'b0;
         if (st.dp_cond) begin
            next_st.cmp = cmp_fp({I_SRC1, st.lo1}, {I_SRC2, st.lo2},
                                 1'b1);
            next_st.cmp.we = 1'b1;
         end
      end else if (I_ISSUE) begin
         case (I_OP)
            fpcc_pkg::OP_CMP_DOUBLE: begin
               next_st.dp_pend = 1'b1;
               next_st.dp_cond = I_COND;
               next_st.lo1     = I_SRC1;
               next_st.lo2     = I_SRC2;
            end
            fpcc_pkg::OP_CMP_SINGLE: begin
               if (I_COND) begin
                  next_st.cmp = cmp_fp({32'h0, I_SRC1}, {32'h0, I_SRC2},
                                       1'b0);
                  next_st.cmp.we = 1'b1;
               end
            end
            fpcc_pkg::OP_CMP_UNSIGNED: begin
               case (I_OPFIELD)
                  fpcc_pkg::OPF_REG_REG: ;
                  fpcc_pkg::OPF_CST_REG:
                     ua = {36'h0, I_SRC1[3:0]};
                  fpcc_pkg::OPF_REG_LONG:
                     ub = {I_SRC2_HI, I_SRC2};
                  fpcc_pkg::OPF_CST_LONG: begin
                     ua = {36'h0, I_SRC1[3:0]};
                     ub = {I_SRC2_HI, I_SRC2};
                  end
                  default:
                     uok = 1'b0;
               endcase
               if (I_COND && uok) begin
                  next_st.cmp     = '0;
                  next_st.cmp.dst = {31'h0, ua < ub};
                  next_st.cmp.we  = 1'b1;
               end
            end
            fpcc_pkg::OP_DOUBLE_TO_INT: begin
               r    = cvt_int({I_SRC2, I_SRC1}, I_RMODE);
               r.we = I_COND;
               next_st.pipe[0] = r;
            end
            fpcc_pkg::OP_DOUBLE_TO_SINGLE: begin
               r    = cvt_sp({I_SRC2, I_SRC1}, I_RMODE);
               r.we = I_COND;
               next_st.pipe[0] = r;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST)
         st <= '0;
      else if (I_CE)
         st <= next_st;
   end

   assign O_CMP_RES = st.cmp;
   assign O_CNV_RES = st.cnv;
   assign O_BUSY    = st.dp_pend;

endmodule

// ===== testbench/fpcc_unit_checker.sv
`timescale 1ns/1ps
module fpcc_unit_checker (
   // clock and reset
   input wire logic                   I_REF_CLK,
   input wire logic                   I_NRST,
   // issue
   input wire logic                   I_CE,
   input wire logic                   I_ISSUE,
   input wire fpcc_pkg::fpcc_op_t     I_OP,
   input wire logic                   I_COND,
   input wire logic [6:0]             I_OPFIELD,
   input wire logic [31:0]            I_SRC1,
   input wire logic [31:0]            I_SRC2,
   // results
   input wire fpcc_pkg::fpcc_result_t O_CMP_RES,
   input wire fpcc_pkg::fpcc_result_t O_CNV_RES,
   input wire logic                   O_BUSY
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_NRST);
   wire logic go   = I_CE && I_ISSUE && !O_BUSY;
   wire logic snan = &I_SRC1[30:23] && |I_SRC1[22:0];
   wire logic dexp = &I_SRC2[30:20];
   wire logic dman = |I_SRC2[19:0] || |I_SRC1;
   ////////////////////////////////////////////////////////////////////////////
   sequence dbl_e1;
      go && I_OP == fpcc_pkg::OP_CMP_DOUBLE ##1 I_CE;
   endsequence
   sequence cnv(c, fpcc_pkg::fpcc_op_t op);
      go && c && I_OP == op ##1 I_CE [*3];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_SGL_LAT: assert property (go && I_COND && I_OP == fpcc_pkg::OP_CMP_SINGLE
      |=> O_CMP_RES.we) else $error("single compare write missing");
   AST_SGL_NAN: assert property (go && I_COND && snan
      && I_OP == fpcc_pkg::OP_CMP_SINGLE |=> O_CMP_RES.dst == 32'h0000_0000
      && O_CMP_RES.flags.unordered && O_CMP_RES.flags.invalid_op)
      else $error("single compare NaN result wrong");
   AST_UNS_VAL: assert property (go && I_COND
      && I_OP == fpcc_pkg::OP_CMP_UNSIGNED && I_OPFIELD == fpcc_pkg::OPF_REG_REG
      |=> O_CMP_RES.we && O_CMP_RES.dst == 32'($past(I_SRC1) < $past(I_SRC2)))
      else $error("unsigned compare value wrong");
   AST_UNS_BAD: assert property (go && I_OP == fpcc_pkg::OP_CMP_UNSIGNED
      && I_OPFIELD[6:2] != 5'h17 |=> !O_CMP_RES.we)
      else $error("unknown opfield wrote");
   AST_NOP: assert property (go && !I_COND && I_OP inside
      {fpcc_pkg::OP_CMP_SINGLE, fpcc_pkg::OP_CMP_UNSIGNED} |=> !O_CMP_RES.we)
      else $error("false predicate wrote");
   AST_DBL: assert property (dbl_e1 |-> O_BUSY ##1
      (!O_BUSY && O_CMP_RES.we == $past(I_COND, 2)))
      else $error("double compare timing wrong");
   AST_CNV_LAT: assert property (cnv(1'b1, fpcc_pkg::OP_DOUBLE_TO_INT)
      |=> O_CNV_RES.we == $past(I_COND, 4)) else $error("conversion latency");
   AST_INT_NAN: assert property (cnv(I_COND && dexp && dman,
      fpcc_pkg::OP_DOUBLE_TO_INT) |=> O_CNV_RES.flags.invalid_op
      && O_CNV_RES.dst == ($past(I_SRC2[31], 4) ? 32'h8000_0000 : 32'h7FFF_FFFF))
      else $error("NaN to int result wrong");
   AST_INT_INF: assert property (cnv(I_COND && dexp && !dman,
      fpcc_pkg::OP_DOUBLE_TO_INT) |=> O_CNV_RES.flags.overflow
      && O_CNV_RES.flags.inexact
      && O_CNV_RES.dst == ($past(I_SRC2[31], 4) ? 32'h8000_0000 : 32'h7FFF_FFFF))
      else $error("infinity to int result wrong");
   AST_SP_INF: assert property (cnv(I_COND && dexp && !dman,
      fpcc_pkg::OP_DOUBLE_TO_SINGLE) |=> O_CNV_RES.flags.infinity_out
      && O_CNV_RES.dst == {$past(I_SRC2[31], 4), fpcc_pkg::SP_INF_MAG})
      else $error("infinity to single result wrong");
endmodule
bind fpcc_unit fpcc_unit_checker u_chk (.I_REF_CLK, .I_NRST, .I_CE, .I_ISSUE,
   .I_OP, .I_COND, .I_OPFIELD, .I_SRC1, .I_SRC2, .O_CMP_RES, .O_CNV_RES,
   .O_BUSY);

// ===== testbench/fpcc_wb_model.sv
`timescale 1ns/1ps
module fpcc_wb_model (
   // clock, reset, enable
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   input  wire logic                   i_ce,
   // results of the unit
   input  wire fpcc_pkg::fpcc_result_t i_cmp,
   input  wire fpcc_pkg::fpcc_result_t i_cnv,
   // destination copies and write counts
   output fpcc_pkg::fpcc_result_t      o_cmp,
   output fpcc_pkg::fpcc_result_t      o_cnv,
   output logic [7:0]                  o_cmp_n,
   output logic [7:0]                  o_cnv_n
);
   // destination side: takes a result only on an enabled write
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cmp   <= '0;
         o_cnv   <= '0;
         o_cmp_n <= 8'h00;
         o_cnv_n <= 8'h00;
      end else if (i_ce) begin
         if (i_cmp.we) begin
            o_cmp   <= i_cmp;
            o_cmp_n <= o_cmp_n + 8'h01;
         end
         if (i_cnv.we) begin
            o_cnv   <= i_cnv;
            o_cnv_n <= o_cnv_n + 8'h01;
         end
      end
   end
endmodule

// ===== testbench/fpcc_unit_bench.sv
`timescale 1ns/1ps
module fpcc_unit_bench;
   localparam fpcc_pkg::fpcc_op_t CS = fpcc_pkg::OP_CMP_SINGLE;
   localparam fpcc_pkg::fpcc_op_t CD = fpcc_pkg::OP_CMP_DOUBLE;
   localparam fpcc_pkg::fpcc_op_t CU = fpcc_pkg::OP_CMP_UNSIGNED;
   localparam fpcc_pkg::fpcc_op_t DI = fpcc_pkg::OP_DOUBLE_TO_INT;
   localparam fpcc_pkg::fpcc_op_t DS = fpcc_pkg::OP_DOUBLE_TO_SINGLE;
   localparam logic [11:0]        IX = 12'h200;
   logic                   clk = 0;
   logic                   nrst = 0;
   logic                   ce = 1;
   logic                   iss = 0;
   fpcc_pkg::fpcc_op_t     op = fpcc_pkg::OP_NONE;
   logic                   cond = 0;
   logic [6:0]             opf = 0;
   logic [31:0]            s1 = 0;
   logic [31:0]            s2 = 0;
   logic [7:0]             hi = 0;
   logic [1:0]             rm = 0;
   logic [1:0]             m;
   logic                   s;
   logic                   t;
   logic [31:0]            e;
   logic [7:0]             c0;
   logic [7:0]             v0;
   logic [7:0]             nc;
   logic [7:0]             nv;
   logic                   busy;
   fpcc_pkg::fpcc_result_t cmp;
   fpcc_pkg::fpcc_result_t cnv;
   fpcc_pkg::fpcc_result_t mc;
   fpcc_pkg::fpcc_result_t mv;
   logic [63:0]            uv [4] = '{64'h0000_0128_FFFF_FFDE,
      64'h0000_0005_0000_0013, 64'h0000_0000_0000_0005, 64'h0000_0014_0000_001E};
   int                     failures = 0;
   int                     check_count = 0;
   always #4 clk = ~clk;
   fpcc_unit DUT (.I_REF_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_ISSUE(iss),
      .I_OP(op), .I_COND(cond), .I_OPFIELD(opf), .I_SRC1(s1), .I_SRC2(s2),
      .I_SRC2_HI(hi), .I_RMODE(rm), .O_CMP_RES(cmp), .O_CNV_RES(cnv),
      .O_BUSY(busy));
   fpcc_wb_model wb (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cmp(cmp),
      .i_cnv(cnv), .o_cmp(mc), .o_cnv(mv), .o_cmp_n(nc), .o_cnv_n(nv));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic go(fpcc_pkg::fpcc_op_t o, logic c, logic [6:0] f,
                     logic [63:0] d, logic [7:0] h, logic [1:0] r);
      @(negedge clk);
      {c0, v0} = {nc, nv};
      op = o;
      {iss, cond, opf, s2, s1, hi, rm} = {1'b1, c, f, d, h, r};
   endtask
   task automatic idle;
      @(negedge clk);
      iss = 0;
   endtask
   task automatic res(logic p, logic [31:0] x, logic [11:0] xf,
                      logic [11:0] fm);
      int i;
      i = 0;
      while ((p ? nv : nc) === (p ? v0 : c0) && i < 10) begin
         @(negedge clk);
         i++;
      end
      if (i == 10) begin
         chk("write", 1, 0);
         final_report;
      end
      chk("dst", x, p ? mv.dst : mc.dst);
      chk("flags", 32'(xf), 32'((p ? mv.flags : mc.flags) & fm));
   endtask
   task automatic none;
      {c0, v0} = {nc, nv};
      repeat (8) @(negedge clk);
      chk("writes", {16'h0000, c0, v0}, {16'h0000, nc, nv});
   endtask
   task automatic cmp1(fpcc_pkg::fpcc_op_t o, logic [6:0] f, logic [63:0] d,
                       logic [7:0] h, logic [31:0] x, logic [11:0] xf);
      go(o, 1, f, d, h, 0);
      idle;
      res(0, x, xf, o == CU ? 12'h000 : 12'hFFF);
   endtask
   task automatic dcmp(logic [63:0] a, logic [63:0] b, logic [31:0] x,
                       logic [11:0] xf);
      go(CD, 1, 0, {b[31:0], a[31:0]}, 0, 0);
      go(CS, 1, 0, {b[63:32], a[63:32]}, 0, 0);
      chk("busy", 1, 32'(busy));
      idle;
      res(0, x, xf, 12'hFFF);
   endtask
   task automatic cv(fpcc_pkg::fpcc_op_t o, logic [63:0] d, logic [1:0] r,
                     logic [31:0] x, logic [11:0] xf, logic [11:0] fm);
      go(o, 1, 0, d, 0, r);
      idle;
      res(1, x, xf, fm);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      nrst = 1;
      cmp1(CS, 0, 64'h4109_999A_C020_0000, 0, 1, 0);
      cmp1(CS, 0, 64'h0000_0000_7FC0_0000, 0, 0, 12'hC04);
      cmp1(CS, 0, 64'h7F80_0001_BF80_0000, 0, 0, 12'hC08);
      cmp1(CS, 0, 64'h0000_0000_0000_0001, 0, 0, 12'h001);
      dcmp(64'h4021_3333_3333_3333, 64'hC004_0000_0000_0000, 0, 0);
      dcmp(64'hC004_0000_0000_0000, 64'h4021_3333_3333_3333, 1, 0);
      dcmp(64'h7FF8_0000_0000_0000, 64'h3FF0_0000_0000_0000, 0, 12'hC04);
      // enable low: result must hold and no write is counted
      go(CS, 1, 0, 64'h4109_999A_C020_0000, 0, 0);
      @(negedge clk);
      {iss, ce} = 2'b00;
      repeat (3) @(negedge clk);
      chk("frozen", 32'(c0), 32'(nc));
      ce = 1;
      res(0, 1, 0, 12'hFFF);
      for (int k = 0; k < 4; k++) begin
         cmp1(CU, 7'h5F - 7'(k), uv[k], 8'(k == 2), 32'(k != 0), 0);
      end
      go(CU, 1, 7'h4F, 64'h0000_0005_0000_0001, 0, 0);
      idle;
      none;
      go(CS, 0, 0, 64'h4109_999A_C020_0000, 0, 0);
      idle;
      none;
      go(DI, 0, 0, 64'h4021_3333_3333_3333, 0, 0);
      idle;
      none;
      for (int k = 0; k < 8; k++) begin
         {s, m} = 3'(k);
         t = m == fpcc_pkg::RM_ZERO || m == (s ? fpcc_pkg::RM_PINF
                                              : fpcc_pkg::RM_NINF);
         e = s ? (t ? 32'hFFFF_FFF8 : 32'hFFFF_FFF7) : (t ? 32'h8 : 32'h9);
         cv(DI, {s, 63'h4021_3333_3333_3333}, m, e, IX, IX);
         t = m == fpcc_pkg::RM_NEAREST || m == (s ? fpcc_pkg::RM_NINF
                                                 : fpcc_pkg::RM_PINF);
         e = {s, t ? fpcc_pkg::SP_INF_MAG : fpcc_pkg::LARGEST_SINGLE_MAGNITUDE};
         cv(DS, {s, 63'h7FE0_0000_0000_0000}, m, e, 12'h300, 12'h300);
         t = m == (s ? fpcc_pkg::RM_NINF : fpcc_pkg::RM_PINF);
         e = {s, t ? fpcc_pkg::SMALLEST_SINGLE_MAGNITUDE : 31'h0000_0000};
         cv(DS, {s, 63'h0010_0000_0000_0000}, m, e, 12'h280, 12'h280);
      end
      cv(DI, 64'h7FF8_0000_0000_0000, 0, 32'h7FFF_FFFF, 12'h400, 12'h400);
      cv(DI, 64'hFFF0_0000_0000_0000, 0, 32'h8000_0000, 12'h300, 12'h300);
      cv(DI, 64'h41E0_0000_0000_0000, 0, 32'h7FFF_FFFF, 12'h300, 12'h300);
      cv(DI, 64'hC1E0_0000_0000_0000, 0, 32'h8000_0000, 0, 12'h100);
      cv(DI, 64'hC1E0_0000_0020_0000, 0, 32'h8000_0000,
         12'h300, 12'h300);
      cv(DI, 64'h8000_0000_0000_0001, 0, 0, 12'h240, 12'h240);
      cv(DS, 64'h4021_3333_3333_3333, 0, 32'h4109_999A, IX, IX);
      cv(DS, 64'h7FF8_0000_0000_0000, 0, 32'h7FFF_FFFF, 12'h020, 12'h020);
      cv(DS, 64'h8000_0000_0000_0001, 0, 32'h8000_0000, 12'h240, 12'h240);
      cv(DS, 64'hFFF0_0000_0000_0000, 0, 32'hFF80_0000, 12'h010, 12'h010);
      final_report;
   end
endmodule
